// ==== shared/prox_pkg.sv ====
// Purpose: shared constants for the proximity cycle controller and its host bridge
// Assumes: one clock hclk at 125 MHz, active-low asynchronous reset hresetn
// Notes: device register offsets are 5-bit indices on the link
// Function
// - irq only while irq_mask_enable bit 5 set; the code keeps a pending irq asserted after bit 5 clears, until the clear code
// - enable bit 3 switches the wait timer
// - sensing_enable bits 2:1, 11b on, 00b off
// - bit 0 gates the internal oscillator
// - hold first cycle 2.72ms after power-on
// - host writes zeros to enable reserved bits
// - ALS period runs 256 minus value steps
// - ALS length resets 0x00, software sets 0xFF
// - integration 256 minus value steps, max 1023
// - host should program integration length 0xFF
// - idle length is 256 minus value steps
// - idle_times_twelve makes each idle step twelvefold
// - host programs idle length before sensing enable
// - below low or above high is out of range
// - 16-bit limits split at offsets 0x08..0x0B
// - filter 0000 interrupts every proximity cycle
// - filter N needs N consecutive out-of-range results
// - filter low nibble reserved, reads zero
// - wait-long is configuration bit 1
// - special code 00101 clears pending irq, self-clearing
// - status bit 5 shows pending interrupt
package prox_pkg;
    // ==============================================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int STEP_TIME_NS = 2720000;
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_MULT = 12;
    localparam int PROX_MAX_COUNT = 1023;
    localparam int STEPS_W = 12;
    // ==============================================================
    // device register indices
    localparam logic [4:0] OFS_ENABLE = 5'h00;
    localparam logic [4:0] OFS_ALS_LEN = 5'h01;
    localparam logic [4:0] OFS_PROX_LEN = 5'h02;
    localparam logic [4:0] OFS_IDLE_LEN = 5'h03;
    localparam logic [4:0] OFS_LOW_LSB = 5'h08;
    localparam logic [4:0] OFS_LOW_MSB = 5'h09;
    localparam logic [4:0] OFS_HIGH_LSB = 5'h0A;
    localparam logic [4:0] OFS_HIGH_MSB = 5'h0B;
    localparam logic [4:0] OFS_FILTER = 5'h0C;
    localparam logic [4:0] OFS_CONFIG = 5'h0D;
    localparam logic [4:0] OFS_STATUS = 5'h13;
    localparam logic [4:0] CODE_IRQ_CLEAR = 5'h05;
    // ==============================================================
    // field positions and masks
    localparam int EN_POWER_BIT = 0;
    localparam int EN_SENSE_LO = 1;
    localparam int EN_WAIT_BIT = 3;
    localparam int EN_IRQ_MASK_BIT = 5;
    localparam int CFG_X12_BIT = 1;
    localparam int ST_PENDING_BIT = 5;
    localparam int FILTER_LO = 4;
    localparam logic [1:0] SENSE_ON = 2'h3;
    localparam logic [7:0] ENABLE_MASK = 8'h2F;
    localparam logic [7:0] CONFIG_MASK = 8'h02;
    localparam logic [7:0] FILTER_MASK = 8'hF0;
    // ==============================================================
    // reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_ALS_LEN = 8'h00;
    localparam logic [7:0] RST_PROX_LEN = 8'hFF;
    localparam logic [7:0] RST_IDLE_LEN = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // ==============================================================
    // host bridge registers (byte addresses)
    localparam logic [7:0] HOST_CMD_OFS = 8'h00;
    localparam logic [7:0] HOST_STAT_OFS = 8'h04;
    localparam int CMD_DATA_LO = 0;
    localparam int CMD_ADDR_LO = 8;
    localparam int CMD_WRITE_BIT = 16;
    localparam int CMD_SPECIAL_BIT = 17;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_IRQ_BIT = 9;
    localparam logic [1:0] LINK_TURN = 2'h2;
endpackage : prox_pkg

// ==== shared/prox_link_if.sv ====
// Purpose: register link and interrupt line between host bridge and sensor
// Assumes: both ends on hclk
// Notes: interrupt is open drain, low while the device pulls
`timescale 1ns/10ps
interface prox_link_if (
    input logic hclk,
    input logic hresetn
);
    logic reg_wr;
    logic reg_rd;
    logic special;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic irq_oe;
    logic irq_n;
    assign irq_n = ~irq_oe;
    modport device (input reg_wr, input reg_rd, input special, input addr, input wdata,
                    output rdata, output irq_oe);
    modport host (output reg_wr, output reg_rd, output special, output addr, output wdata,
                  input rdata, input irq_n);
endinterface : prox_link_if

// ==== hw/step_timer.sv ====
// Purpose: counts a number of 2.72ms steps and pulses done at the end
// Assumes: steps of zero behave as one step
// Notes: abort wins over start
`timescale 1ns/10ps
module step_timer #(
    parameter int STEP_CYCLES = prox_pkg::STEP_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic start,
    input wire logic abort,
    input wire logic [prox_pkg::STEPS_W-1:0] steps,
    // result
    output logic done
);
    localparam int PW = (STEP_CYCLES > 2) ? $clog2(STEP_CYCLES) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(STEP_CYCLES - 1);
    localparam logic [prox_pkg::STEPS_W-1:0] ONE = 12'h001;

    if (STEP_CYCLES < 2) begin : g_check
        $error("step_timer needs STEP_CYCLES of at least 2");
    end

    logic [PW-1:0] pre;
    logic [prox_pkg::STEPS_W-1:0] left;
    logic active;
    wire pre_wrap = active && (pre == PRE_LAST);
    wire last_step = pre_wrap && (left <= ONE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre <= '0;
            left <= '0;
            active <= 1'b0;
            done <= 1'b0;
        end else if (abort || start) begin
            pre <= '0;
            left <= steps;
            active <= !abort;
            done <= 1'b0;
        end else begin
            pre <= pre_wrap ? '0 : (active ? pre + PW'(1) : pre);
            left <= pre_wrap ? left - ONE : left;
            active <= active && !last_step;
            done <= last_step;
        end
    end
endmodule : step_timer

// ==== hw/prox_device.sv ====
// Purpose: proximity sensor control: registers, cycle sequencer, interrupt filter
// Assumes: prox_sample is stable on hclk when an integration ends
// Notes: the analog front end is outside; integrating tells it when to sample
//
// Implementation choice: the strobed prox_link_if register link to the registers.
`timescale 1ns/10ps
module prox_device #(
    parameter int STEP_CYCLES = prox_pkg::STEP_CYCLES
) (
    // link to host
    prox_link_if.device link,
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // analog front end
    input wire logic [15:0] prox_sample,
    output logic osc_on,
    output logic integrating
);
    typedef enum logic [2:0] {
        S_OFF = 3'b000,
        S_WARM = 3'b001,
        S_READY = 3'b011,
        S_ALS = 3'b010,
        S_PROX = 3'b110,
        S_IDLE = 3'b111
    } seq_state_t;

    // ==============================================================
    // registers
    logic [7:0] enable;
    logic [7:0] als_period_length;
    logic [7:0] prox_integration_length;
    logic [7:0] idle_period_length;
    logic [7:0] low_limit_lsb;
    logic [7:0] low_limit_msb;
    logic [7:0] high_limit_lsb;
    logic [7:0] high_limit_msb;
    logic [7:0] irq_filter_count;
    logic [7:0] config_reg;
    logic irq_pending_flag;
    logic [3:0] run_count;
    logic [7:0] rdata;
    seq_state_t state;
    seq_state_t next_state;

    wire oscillator_power_on = enable[prox_pkg::EN_POWER_BIT];
    wire sensing_enable = enable[prox_pkg::EN_SENSE_LO +: 2] == prox_pkg::SENSE_ON;
    wire wait_enable = enable[prox_pkg::EN_WAIT_BIT];
    wire irq_mask_enable = enable[prox_pkg::EN_IRQ_MASK_BIT];
    wire idle_times_twelve = config_reg[prox_pkg::CFG_X12_BIT];
    wire [3:0] out_of_range_count_field = irq_filter_count[prox_pkg::FILTER_LO +: 4];

    wire wr_hit = link.reg_wr;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable <= prox_pkg::RST_ENABLE;
            als_period_length <= prox_pkg::RST_ALS_LEN;
            prox_integration_length <= prox_pkg::RST_PROX_LEN;
            idle_period_length <= prox_pkg::RST_IDLE_LEN;
            low_limit_lsb <= prox_pkg::RST_ZERO;
            low_limit_msb <= prox_pkg::RST_ZERO;
            high_limit_lsb <= prox_pkg::RST_ZERO;
            high_limit_msb <= prox_pkg::RST_ZERO;
            irq_filter_count <= prox_pkg::RST_ZERO;
            config_reg <= prox_pkg::RST_ZERO;
        end else if (wr_hit) begin
            unique case (link.addr)
                prox_pkg::OFS_ENABLE: enable <= link.wdata & prox_pkg::ENABLE_MASK;
                prox_pkg::OFS_ALS_LEN: als_period_length <= link.wdata;
                prox_pkg::OFS_PROX_LEN: prox_integration_length <= link.wdata;
                prox_pkg::OFS_IDLE_LEN: idle_period_length <= link.wdata;
                prox_pkg::OFS_LOW_LSB: low_limit_lsb <= link.wdata;
                prox_pkg::OFS_LOW_MSB: low_limit_msb <= link.wdata;
                prox_pkg::OFS_HIGH_LSB: high_limit_lsb <= link.wdata;
                prox_pkg::OFS_HIGH_MSB: high_limit_msb <= link.wdata;
                prox_pkg::OFS_FILTER: irq_filter_count <= link.wdata & prox_pkg::FILTER_MASK;
                prox_pkg::OFS_CONFIG: config_reg <= link.wdata & prox_pkg::CONFIG_MASK;
                default: ;
            endcase
        end
    end

    // ==============================================================
    // read back, one cycle after the read strobe
    logic [7:0] read_mux;
    always_comb begin
        read_mux = 8'h00;
        unique case (link.addr)
            prox_pkg::OFS_ENABLE: read_mux = enable;
            prox_pkg::OFS_ALS_LEN: read_mux = als_period_length;
            prox_pkg::OFS_PROX_LEN: read_mux = prox_integration_length;
            prox_pkg::OFS_IDLE_LEN: read_mux = idle_period_length;
            prox_pkg::OFS_LOW_LSB: read_mux = low_limit_lsb;
            prox_pkg::OFS_LOW_MSB: read_mux = low_limit_msb;
            prox_pkg::OFS_HIGH_LSB: read_mux = high_limit_lsb;
            prox_pkg::OFS_HIGH_MSB: read_mux = high_limit_msb;
            prox_pkg::OFS_FILTER: read_mux = irq_filter_count;
            prox_pkg::OFS_CONFIG: read_mux = config_reg;
            prox_pkg::OFS_STATUS: read_mux[prox_pkg::ST_PENDING_BIT] = irq_pending_flag;
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata <= 8'h00;
        end else if (link.reg_rd) begin
            rdata <= read_mux;
        end
    end
    assign link.rdata = rdata;

    // ==============================================================
    // cycle sequencer
    logic timer_start;
    logic timer_done;
    logic [prox_pkg::STEPS_W-1:0] timer_steps;
    wire [8:0] als_steps = 9'h100 - {1'b0, als_period_length};
    wire [8:0] integration_steps = 9'h100 - {1'b0, prox_integration_length};
    wire [8:0] idle_steps = 9'h100 - {1'b0, idle_period_length};
    wire [prox_pkg::STEPS_W-1:0] idle_total = idle_times_twelve ?
        prox_pkg::STEPS_W'(idle_steps * prox_pkg::IDLE_MULT) : {3'h0, idle_steps};

    always_comb begin
        next_state = state;
        timer_start = 1'b0;
        timer_steps = '0;
        unique case (state)
            S_OFF: if (oscillator_power_on) begin
                // warm-up holds off sensing even if software starts at once
                next_state = S_WARM;
                timer_start = 1'b1;
                timer_steps = 12'h001;
            end
            S_WARM: if (timer_done) next_state = S_READY;
            S_READY: if (sensing_enable) begin
                next_state = S_ALS;
                timer_start = 1'b1;
                timer_steps = {3'h0, als_steps};
            end
            S_ALS: if (timer_done) begin
                next_state = S_PROX;
                timer_start = 1'b1;
                timer_steps = {3'h0, integration_steps};
            end
            S_PROX: if (timer_done) begin
                if (wait_enable) begin
                    next_state = S_IDLE;
                    timer_start = 1'b1;
                    timer_steps = idle_total;
                end else if (sensing_enable) begin
                    next_state = S_ALS;
                    timer_start = 1'b1;
                    timer_steps = {3'h0, als_steps};
                end else begin
                    next_state = S_READY;
                end
            end
            S_IDLE: if (timer_done) begin
                if (sensing_enable) begin
                    next_state = S_ALS;
                    timer_start = 1'b1;
                    timer_steps = {3'h0, als_steps};
                end else begin
                    next_state = S_READY;
                end
            end
        endcase
        if (!oscillator_power_on) begin
            next_state = S_OFF;
            timer_start = 1'b0;
        end
    end

    step_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(timer_start),
        .abort(!oscillator_power_on),
        .steps(timer_steps),
        .done(timer_done)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_OFF;
            osc_on <= 1'b0;
            integrating <= 1'b0;
        end else begin
            state <= next_state;
            osc_on <= next_state != S_OFF;
            integrating <= next_state == S_PROX;
        end
    end

    // ==============================================================
    // threshold compare and persistence filter
    wire prox_end = (state == S_PROX) && timer_done && oscillator_power_on;
    wire [17:0] max_count = 18'(integration_steps * prox_pkg::PROX_MAX_COUNT);
    wire [15:0] result = ({2'h0, prox_sample} > max_count) ? max_count[15:0] : prox_sample;
    wire [15:0] low_limit = {low_limit_msb, low_limit_lsb};
    wire [15:0] high_limit = {high_limit_msb, high_limit_lsb};
    wire out_of_range = (result < low_limit) || (result > high_limit);
    wire [3:0] run_next = (run_count == 4'hF) ? run_count : run_count + 4'h1;
    wire filter_hit = (out_of_range_count_field == 4'h0) ||
        (out_of_range && (run_next >= out_of_range_count_field));
    wire irq_set = prox_end && filter_hit && irq_mask_enable;
    wire irq_clear = link.special && (link.addr == prox_pkg::CODE_IRQ_CLEAR);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_count <= 4'h0;
            irq_pending_flag <= 1'b0;
            link.irq_oe <= 1'b0;
        end else begin
            if (prox_end) begin
                run_count <= out_of_range ? run_next : 4'h0;
            end
            // a new event in the clearing cycle stays pending
            irq_pending_flag <= irq_set || (irq_pending_flag && !irq_clear);
            link.irq_oe <= irq_set || (irq_pending_flag && !irq_clear);
        end
    end
endmodule : prox_device

// ==== hw/prox_host.sv ====
// Purpose: AHB-Lite slave that turns software commands into sensor link transfers
// Assumes: one slave on the bus, single word transfers only
// Notes: always zero wait states; commands while busy are dropped
`timescale 1ns/10ps
module prox_host (
    // link to device
    prox_link_if.host link,
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    // ==============================================================
    // bus decode
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] cmd;
    logic [7:0] read_byte;
    logic [1:0] phase;
    logic irq_meta;
    logic irq_sync;
    logic reg_wr;
    logic reg_rd;
    logic special;
    logic [4:0] addr;
    logic [7:0] wdata;

    wire take = hsel && htrans[1] && hready;
    wire busy = phase != 2'h0;
    wire launch = wr_pend && (wr_addr == prox_pkg::HOST_CMD_OFS) && !busy;
    wire cmd_write = hwdata[prox_pkg::CMD_WRITE_BIT];
    wire cmd_special = hwdata[prox_pkg::CMD_SPECIAL_BIT];
    wire [4:0] cmd_addr = hwdata[prox_pkg::CMD_ADDR_LO +: 5];
    wire [7:0] cmd_data = hwdata[prox_pkg::CMD_DATA_LO +: 8];
    // reserved enable bits are forced low so software slips cannot set them
    wire [7:0] safe_data = (cmd_addr == prox_pkg::OFS_ENABLE) ?
        (cmd_data & prox_pkg::ENABLE_MASK) : cmd_data;
    wire [31:0] status_word = {22'h0, irq_sync, busy, read_byte};
    wire [31:0] read_mux = (haddr[7:0] == prox_pkg::HOST_CMD_OFS) ? cmd :
        ((haddr[7:0] == prox_pkg::HOST_STAT_OFS) ? status_word : 32'h0000_0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= take && hwrite;
            wr_addr <= haddr[7:0];
            hrdata <= (take && !hwrite) ? read_mux : hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ==============================================================
    // link sequencing: strobe, device turn, capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd <= 32'h0000_0000;
            phase <= 2'h0;
            read_byte <= 8'h00;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            special <= 1'b0;
            addr <= 5'h00;
            wdata <= 8'h00;
        end else begin
            cmd <= launch ? {14'h0, cmd_special, cmd_write, 3'h0, cmd_addr, safe_data} : cmd;
            phase <= launch ? prox_pkg::LINK_TURN : (busy ? phase - 2'h1 : phase);
            read_byte <= (phase == 2'h1 && !cmd[prox_pkg::CMD_WRITE_BIT] &&
                !cmd[prox_pkg::CMD_SPECIAL_BIT]) ? link.rdata : read_byte;
            reg_wr <= launch && cmd_write && !cmd_special;
            reg_rd <= launch && !cmd_write && !cmd_special;
            special <= launch && cmd_special;
            addr <= launch ? cmd_addr : addr;
            wdata <= launch ? safe_data : wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_meta <= 1'b0;
            irq_sync <= 1'b0;
        end else begin
            irq_meta <= !link.irq_n;
            irq_sync <= irq_meta;
        end
    end

    assign link.reg_wr = reg_wr;
    assign link.reg_rd = reg_rd;
    assign link.special = special;
    assign link.addr = addr;
    assign link.wdata = wdata;
endmodule : prox_host

// ==== verification/prox_link_properties.sv ====
// Purpose: link properties between host bridge and sensor control
// Assumes: one clock domain, reset active low
// Notes: enable bits are shadowed from writes seen on the link
`timescale 1ns/10ps
module prox_link_properties (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic special,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic irq_oe
);
    logic mask_en;
    logic power_on;
    wire any_strobe = reg_wr | reg_rd | special;
    wire clear_cmd = special & (addr == prox_pkg::CODE_IRQ_CLEAR);
    wire enable_wr = reg_wr & (addr == prox_pkg::OFS_ENABLE);
    wire filter_rd = reg_rd & (addr == prox_pkg::OFS_FILTER);
    // ==============================================================
    // shadow of the enable byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_en <= 1'b0;
            power_on <= 1'b0;
        end else if (enable_wr) begin
            mask_en <= wdata[prox_pkg::EN_IRQ_MASK_BIT];
            power_on <= wdata[prox_pkg::EN_POWER_BIT];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==============================================================
    // properties
    property p_strobe_one; $onehot0({reg_wr, reg_rd, special}); endproperty
    a_strobe_one: assert property (p_strobe_one) else $error("link strobes overlap");
    property p_strobe_gap; any_strobe |=> !any_strobe; endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("link strobes too close");
    property p_irq_mask; $rose(irq_oe) |-> mask_en; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    property p_irq_hold; irq_oe && !clear_cmd |=> irq_oe; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_irq_clear; irq_oe && clear_cmd |=> !irq_oe; endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
    property p_off_quiet; !power_on && !irq_oe |=> !irq_oe; endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("irq while off");
    property p_filter_rsvd; filter_rd |=> rdata[3:0] == 4'h0; endproperty
    a_filter_rsvd: assert property (p_filter_rsvd) else $error("filter low bits set");
    property p_rdata_hold; !reg_rd |=> $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_enable_rsvd; enable_wr |-> (wdata & ~prox_pkg::ENABLE_MASK) == 8'h00; endproperty
    a_enable_rsvd: assert property (p_enable_rsvd) else $error("reserved bits sent");
endmodule : prox_link_properties

// ==== verification/proximity_cycle_and_interrupt_control_tb.sv ====
// Purpose: self-checking bench for host bridge and sensor control
// Assumes: step shortened to STEP cycles, zero-wait slave
// Notes: cycle counts allow two cycles of phase hand-over slack
`timescale 1ns/10ps
module proximity_cycle_and_interrupt_control_tb;
    localparam int STEP = 8;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, osc_on, integrating;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] prox_sample;
    int error_cnt, check_count, on_cnt, on_at_rise;
    prox_link_if link (.hclk(hclk), .hresetn(hresetn));
    prox_device #(.STEP_CYCLES(STEP)) prox_device_i (.link(link), .hclk(hclk),
        .hresetn(hresetn), .prox_sample(prox_sample), .osc_on(osc_on), .integrating(integrating));
    prox_host prox_host_i (.link(link), .hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    prox_link_properties prox_link_properties_i (.hclk(hclk), .hresetn(hresetn),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .special(link.special), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .irq_oe(link.irq_oe));
    // ==============================================================
    // clock, power-on age, watchdog
    initial forever #4 hclk = ~hclk;
    always @(posedge hclk) begin
        on_cnt <= (osc_on === 1'b1) ? on_cnt + 1 : 0;
        if (integrating === 1'b1 && on_at_rise < 0) on_at_rise <= on_cnt;
    end
    initial begin
        repeat (60000) @(posedge hclk);
        error_cnt++;
        stop_test();
    end
    // ==============================================================
    // helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask : chk
    task automatic chk_near(input int g, input int e);
        check_count++;
        if (g < e - 2 || g > e + 2) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask : chk_near
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    // k is {special, write}; returns once the bridge is idle again
    task automatic cmd(input logic [4:0] i, input logic [7:0] d, input logic [1:0] k,
                       output logic [7:0] b);
        logic [31:0] r;
        ahb(prox_pkg::HOST_CMD_OFS, 1'b1, {14'h0000, k, 3'h0, i, d}, r);
        r = 32'h00000100;
        while (r[prox_pkg::STAT_BUSY_BIT] !== 1'b0) ahb(prox_pkg::HOST_STAT_OFS, 1'b0, 32'h0, r);
        b = r[7:0];
    endtask : cmd
    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        logic [7:0] b;
        cmd(i, d, 2'h1, b);
    endtask : wr
    task automatic rd_chk(input logic [4:0] i, input logic [7:0] e);
        logic [7:0] b;
        cmd(i, 8'h00, 2'h0, b);
        chk(32'(b), 32'(e));
    endtask : rd_chk
    // whole integration length, then the gap to the next integration
    task automatic span(output int hi, output int gap);
        {hi, gap} = 64'h0;
        while (integrating !== 1'b1) @(posedge hclk);
        while (integrating === 1'b1) begin
            @(posedge hclk);
            hi++;
        end
        while (integrating !== 1'b1) begin
            @(posedge hclk);
            gap++;
        end
    endtask : span
    // ==============================================================
    // scenarios
    task automatic t_regs();
        logic [31:0] r;
        rd_chk(prox_pkg::OFS_ALS_LEN, 8'h00);
        ahb(8'h20, 1'b0, 32'h0, r);
        chk(r, 32'h0);
        chk(32'(hresp), 32'h0);
        wr(prox_pkg::OFS_FILTER, 8'hFF);
        rd_chk(prox_pkg::OFS_FILTER, 8'hF0);
        wr(prox_pkg::OFS_LOW_LSB, 8'h34);
        rd_chk(prox_pkg::OFS_LOW_LSB, 8'h34);
        wr(prox_pkg::OFS_ENABLE, 8'hD0);
        rd_chk(prox_pkg::OFS_ENABLE, 8'h00);
    endtask : t_regs
    task automatic t_timing();
        int hi, gap;
        wr(prox_pkg::OFS_FILTER, 8'h00);
        wr(prox_pkg::OFS_ALS_LEN, 8'hFF);
        wr(prox_pkg::OFS_PROX_LEN, 8'hFE);
        wr(prox_pkg::OFS_CONFIG, 8'h02);
        wr(prox_pkg::OFS_IDLE_LEN, 8'hFF);
        wr(prox_pkg::OFS_ENABLE, 8'h0F);
        span(hi, gap);
        chk_near(on_at_rise, 2 * STEP + 3);
        span(hi, gap);
        chk_near(hi, 2 * STEP);
        chk_near(gap, 13 * STEP);
        chk(link.irq_n, 1'b1);
        wr(prox_pkg::OFS_CONFIG, 8'h00);
        wr(prox_pkg::OFS_IDLE_LEN, 8'hB6);
        span(hi, gap);
        span(hi, gap);
        chk_near(gap, 75 * STEP);
        wr(prox_pkg::OFS_ENABLE, 8'h07);
        span(hi, gap);
        span(hi, gap);
        chk_near(gap, STEP);
    endtask : t_timing
    task automatic t_irq();
        int hi, gap;
        logic [7:0] b;
        wr(prox_pkg::OFS_LOW_MSB, 8'h01);
        wr(prox_pkg::OFS_HIGH_MSB, 8'h02);
        wr(prox_pkg::OFS_PROX_LEN, 8'hFF);
        wr(prox_pkg::OFS_ENABLE, 8'h27);
        span(hi, gap);
        chk(link.irq_n, 1'b0);
        rd_chk(prox_pkg::OFS_STATUS, 8'h20);
        wr(prox_pkg::OFS_FILTER, 8'h20);
        cmd(prox_pkg::CODE_IRQ_CLEAR, 8'h00, 2'h2, b);
        span(hi, gap);
        chk(link.irq_n, 1'b1);
        prox_sample <= 16'h0050;
        span(hi, gap);
        chk(link.irq_n, 1'b1);
        span(hi, gap);
        chk(link.irq_n, 1'b0);
        prox_sample <= 16'h0250;
        wr(prox_pkg::OFS_FILTER, 8'h10);
        cmd(prox_pkg::CODE_IRQ_CLEAR, 8'h00, 2'h2, b);
        span(hi, gap);
        chk(link.irq_n, 1'b0);
        wr(prox_pkg::OFS_ENABLE, 8'h01);
        repeat (40) @(posedge hclk);
        chk(integrating, 1'b0);
        cmd(prox_pkg::CODE_IRQ_CLEAR, 8'h00, 2'h2, b);
        wr(prox_pkg::OFS_ENABLE, 8'h00);
        chk(osc_on, 1'b0);
    endtask : t_irq
    task automatic stop_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        {error_cnt, check_count, on_cnt, on_at_rise} = {32'h0, 32'h0, 32'h0, 32'hFFFFFFFF};
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        prox_sample = 16'h0180;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_timing();
        t_irq();
        stop_test();
    end
endmodule : proximity_cycle_and_interrupt_control_tb
